// *** gmr_regs.sv ***
// graphics memory region register bank behind an axi4-lite slave
// assumes update strobes and the bus are synchronous to aclk
`timescale 1ns/10ps
`default_nettype none

module gmr_regs #(
	parameter int ADDR_W = 12
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic internal_update,
	input wire logic external_update,
	output logic [gmr_pkg::WIDTH_BITS-1:0] width_field,
	output logic [gmr_pkg::HEIGHT_BITS-1:0] height_field,
	output logic shown_buffer_select,
	output logic [gmr_pkg::FB_BITS-1:0] display_addr_top,
	output logic [gmr_pkg::FB_BITS-1:0] origin_addr_top,
	output logic [gmr_pkg::LIST_TOP_BITS+gmr_pkg::LIST_BOTTOM_BITS-1:0] list_addr,
	output logic [gmr_pkg::SOURCE_BITS-1:0] source_addr_top,
	output logic [gmr_pkg::WORK_BITS-1:0] work_addr_top
);

	// ***************************************
	// state
	// ***************************************
	typedef struct packed {
		gmr_pkg::gmr_wr_t wr;
		gmr_pkg::gmr_rd_t rd;
		logic aw_got;
		logic [9:0] aw_idx;
		logic w_got;
		logic [15:0] w_data;
		logic [1:0] w_strb;
		logic awready;
		logic wready;
		logic arready;
		logic [1:0] bresp;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [gmr_pkg::WIDTH_BITS-1:0] width;
		logic [gmr_pkg::HEIGHT_BITS-1:0] height;
		logic [gmr_pkg::FB_BITS-1:0] fb0_pend;
		logic [gmr_pkg::FB_BITS-1:0] fb1_pend;
		logic [gmr_pkg::FB_BITS-1:0] fb0_act;
		logic [gmr_pkg::FB_BITS-1:0] fb1_act;
		logic sel;
		logic [gmr_pkg::FB_BITS-1:0] shown;
		logic [gmr_pkg::FB_BITS-1:0] origin;
		logic [gmr_pkg::LIST_TOP_BITS-1:0] list_top;
		logic [gmr_pkg::LIST_BOTTOM_BITS-1:0] list_bottom;
		logic [gmr_pkg::SOURCE_BITS-1:0] source_top;
		logic [gmr_pkg::WORK_BITS-1:0] work_top;
	} gmr_state_t;

	gmr_state_t st;
	gmr_state_t next_st;

	// byte-lane merge of a 16-bit register image
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] data,
		input logic [1:0] strb);
		logic [15:0] res;
		res = old;
		if (strb[0]) begin
			res[7:0] = data[7:0];
		end
		if (strb[1]) begin
			res[15:8] = data[15:8];
		end
		return res;
	endfunction

	// register image as software sees it; reserved bits read zero
	function automatic logic [15:0] image(input gmr_state_t s, input logic [9:0] idx);
		logic [15:0] v;
		v = 16'h0000;
		if (idx == gmr_pkg::IDX_DISPLAY_WIDTH) begin
			v[gmr_pkg::WIDTH_BITS-1:0] = s.width;
		end else if (idx == gmr_pkg::IDX_DISPLAY_HEIGHT) begin
			v[gmr_pkg::HEIGHT_BITS-1:0] = s.height;
		end else if (idx == gmr_pkg::IDX_FB_ZERO_BASE) begin
			v[gmr_pkg::FB_BITS-1:0] = s.fb0_pend;
		end else if (idx == gmr_pkg::IDX_FB_ONE_BASE) begin
			v[gmr_pkg::FB_BITS-1:0] = s.fb1_pend;
		end else if (idx == gmr_pkg::IDX_LIST_BASE_HIGH) begin
			v[gmr_pkg::LIST_TOP_BITS-1:0] = s.list_top;
		end else if (idx == gmr_pkg::IDX_LIST_BASE_LOW) begin
			v[15:gmr_pkg::LIST_BOTTOM_LSB] = s.list_bottom;
		end else if (idx == gmr_pkg::IDX_SOURCE_BASE) begin
			v[gmr_pkg::SOURCE_BITS:gmr_pkg::SOURCE_LSB] = s.source_top;
		end else if (idx == gmr_pkg::IDX_WORK_BASE) begin
			v[gmr_pkg::WORK_BITS-1:0] = s.work_top;
		end else if (idx == gmr_pkg::IDX_BUFFER_CONTROL) begin
			v[gmr_pkg::SELECT_BIT] = s.sel;
		end else if (idx == gmr_pkg::IDX_ACTIVE_STATUS) begin
			v[gmr_pkg::FB_BITS-1:0] = s.shown;
			v[gmr_pkg::ORIGIN_STATUS_LSB+gmr_pkg::FB_BITS-1:gmr_pkg::ORIGIN_STATUS_LSB] = s.origin;
		end
		return v;
	endfunction

	// mapped: the memory-control group plus the two buffer words
	function automatic logic mapped(input logic [9:0] idx);
		return (idx >= gmr_pkg::IDX_DISPLAY_WIDTH && idx <= gmr_pkg::IDX_GROUP_LAST) ||
			idx == gmr_pkg::IDX_BUFFER_CONTROL || idx == gmr_pkg::IDX_ACTIVE_STATUS;
	endfunction

	// ***************************************
	// next state
	// ***************************************
	always_comb begin
		logic [15:0] wv;
		logic [9:0] ridx;
		wv = 16'h0000;
		ridx = s_axi_araddr[11:2];
		next_st = st;

		// address and data are taken in either order
		if (s_axi_awvalid && st.awready) begin
			next_st.aw_got = 1'b1;
			next_st.aw_idx = s_axi_awaddr[11:2];
		end
		if (s_axi_wvalid && st.wready) begin
			next_st.w_got = 1'b1;
			next_st.w_data = s_axi_wdata[15:0];
			next_st.w_strb = s_axi_wstrb[1:0];
		end

		case (st.wr)
			gmr_pkg::GMR_W_IDLE: begin
				if (next_st.aw_got && next_st.w_got) begin
					wv = merge16(image(st, next_st.aw_idx), next_st.w_data, next_st.w_strb);
					next_st.aw_got = 1'b0;
					next_st.w_got = 1'b0;
					next_st.wr = gmr_pkg::GMR_W_RESP;
					next_st.bresp = mapped(next_st.aw_idx) ? gmr_pkg::RESP_OKAY :
						gmr_pkg::RESP_SLVERR;
					if (next_st.aw_idx == gmr_pkg::IDX_DISPLAY_WIDTH) begin
						next_st.width = wv[gmr_pkg::WIDTH_BITS-1:0];
					end else if (next_st.aw_idx == gmr_pkg::IDX_DISPLAY_HEIGHT) begin
						next_st.height = wv[gmr_pkg::HEIGHT_BITS-1:0];
					end else if (next_st.aw_idx == gmr_pkg::IDX_FB_ZERO_BASE) begin
						next_st.fb0_pend = wv[gmr_pkg::FB_BITS-1:0];
					end else if (next_st.aw_idx == gmr_pkg::IDX_FB_ONE_BASE) begin
						next_st.fb1_pend = wv[gmr_pkg::FB_BITS-1:0];
					end else if (next_st.aw_idx == gmr_pkg::IDX_LIST_BASE_HIGH) begin
						next_st.list_top = wv[gmr_pkg::LIST_TOP_BITS-1:0];
					end else if (next_st.aw_idx == gmr_pkg::IDX_LIST_BASE_LOW) begin
						next_st.list_bottom = wv[15:gmr_pkg::LIST_BOTTOM_LSB];
					end else if (next_st.aw_idx == gmr_pkg::IDX_SOURCE_BASE) begin
						next_st.source_top = wv[gmr_pkg::SOURCE_BITS:gmr_pkg::SOURCE_LSB];
					end else if (next_st.aw_idx == gmr_pkg::IDX_WORK_BASE) begin
						next_st.work_top = wv[gmr_pkg::WORK_BITS-1:0];
					end else if (next_st.aw_idx == gmr_pkg::IDX_BUFFER_CONTROL) begin
						next_st.sel = wv[gmr_pkg::SELECT_BIT];
					end
				end
			end
			gmr_pkg::GMR_W_RESP: begin
				if (s_axi_bready) begin
					next_st.wr = gmr_pkg::GMR_W_IDLE;
				end
			end
			default: begin
				next_st.wr = gmr_pkg::GMR_W_IDLE;
			end
		endcase

		// read: one cycle from address to data
		case (st.rd)
			gmr_pkg::GMR_R_IDLE: begin
				if (s_axi_arvalid && st.arready) begin
					next_st.rd = gmr_pkg::GMR_R_DATA;
					next_st.rdata = {16'h0000, image(st, ridx)};
					next_st.rresp = mapped(ridx) ? gmr_pkg::RESP_OKAY :
						gmr_pkg::RESP_SLVERR;
				end
			end
			gmr_pkg::GMR_R_DATA: begin
				if (s_axi_rready) begin
					next_st.rd = gmr_pkg::GMR_R_IDLE;
				end
			end
			default: begin
				next_st.rd = gmr_pkg::GMR_R_IDLE;
			end
		endcase

		// select clears before routing, so display and flag never disagree
		if (!aresetn) begin
			next_st.sel = 1'b0;
		end

		// pending copy moves only at its update event
		if (internal_update) begin
			if (next_st.sel) begin
				next_st.fb1_act = next_st.fb1_pend;
			end else begin
				next_st.fb0_act = next_st.fb0_pend;
			end
		end
		if (external_update) begin
			if (next_st.sel) begin
				next_st.fb0_act = next_st.fb0_pend;
			end else begin
				next_st.fb1_act = next_st.fb1_pend;
			end
		end

		// select flag splits display and origin
		next_st.shown = next_st.sel ? next_st.fb1_act : next_st.fb0_act;
		next_st.origin = next_st.sel ? next_st.fb0_act : next_st.fb1_act;

		// ready flags registered so outputs come from flip-flops
		next_st.awready = !next_st.aw_got && next_st.wr == gmr_pkg::GMR_W_IDLE;
		next_st.wready = !next_st.w_got && next_st.wr == gmr_pkg::GMR_W_IDLE;
		next_st.arready = next_st.rd == gmr_pkg::GMR_R_IDLE;

		// reset here touches only bus control; region fields kept, select cleared above
		if (!aresetn) begin
			next_st.wr = gmr_pkg::GMR_W_IDLE;
			next_st.rd = gmr_pkg::GMR_R_IDLE;
			next_st.aw_got = 1'b0;
			next_st.w_got = 1'b0;
			next_st.awready = 1'b0;
			next_st.wready = 1'b0;
			next_st.arready = 1'b0;
			next_st.bresp = gmr_pkg::RESP_OKAY;
			next_st.rresp = gmr_pkg::RESP_OKAY;
			next_st.rdata = 32'h00000000;
		end
	end

	// ***************************************
	// registers
	// ***************************************
	// no reset branch: field contents must survive reset
	always_ff @(posedge aclk) begin
		st <= next_st;
	end

	// ***************************************
	// outputs
	// ***************************************
	assign s_axi_awready = st.awready;
	assign s_axi_wready = st.wready;
	assign s_axi_bvalid = st.wr == gmr_pkg::GMR_W_RESP;
	assign s_axi_bresp = st.bresp;
	assign s_axi_arready = st.arready;
	assign s_axi_rvalid = st.rd == gmr_pkg::GMR_R_DATA;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;
	assign width_field = st.width;
	assign height_field = st.height;
	assign shown_buffer_select = st.sel;
	assign display_addr_top = st.shown;
	assign origin_addr_top = st.origin;
	assign list_addr = {st.list_top, st.list_bottom};
	assign source_addr_top = st.source_top;
	// same work base for either pixel depth
	assign work_addr_top = st.work_top;

endmodule

`default_nettype wire

// *** gmr_pkg.sv ***
// graphics memory region registers: shared constants and types
// assumes a 32-bit axi4-lite slave with one register per aligned word
package gmr_pkg;

	// ***************************************
	// register indices (byte address = index * 4)
	// ***************************************
	localparam logic [9:0] IDX_DISPLAY_WIDTH = 10'h008;
	localparam logic [9:0] IDX_DISPLAY_HEIGHT = 10'h009;
	localparam logic [9:0] IDX_FB_ZERO_BASE = 10'h00a;
	localparam logic [9:0] IDX_FB_ONE_BASE = 10'h00b;
	localparam logic [9:0] IDX_LIST_BASE_HIGH = 10'h00c;
	localparam logic [9:0] IDX_LIST_BASE_LOW = 10'h00d;
	localparam logic [9:0] IDX_SOURCE_BASE = 10'h00e;
	localparam logic [9:0] IDX_WORK_BASE = 10'h00f;
	localparam logic [9:0] IDX_GROUP_LAST = 10'h012;
	localparam logic [9:0] IDX_BUFFER_CONTROL = 10'h020;
	localparam logic [9:0] IDX_ACTIVE_STATUS = 10'h021;

	// ***************************************
	// field widths and positions
	// ***************************************
	localparam int WIDTH_BITS = 10;
	localparam int HEIGHT_BITS = 9;
	localparam int FB_BITS = 6;
	localparam int LIST_TOP_BITS = 7;
	localparam int LIST_BOTTOM_BITS = 11;
	localparam int LIST_BOTTOM_LSB = 5;
	localparam int SOURCE_BITS = 6;
	localparam int SOURCE_LSB = 1;
	localparam int WORK_BITS = 7;
	localparam int ORIGIN_STATUS_LSB = 8;
	localparam int SELECT_BIT = 0;

	// ***************************************
	// bus answers
	// ***************************************
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// one-bit gray sequences for the bus channels
	typedef enum logic [0:0] {
		GMR_W_IDLE = 1'h0,
		GMR_W_RESP = 1'h1
	} gmr_wr_t;

	typedef enum logic [0:0] {
		GMR_R_IDLE = 1'h0,
		GMR_R_DATA = 1'h1
	} gmr_rd_t;

endpackage

// *** gmr_props.sv ***
// assertions for the region register bank, bound onto gmr_regs
// assumes every signal belongs to the aclk domain
`timescale 1ns/10ps
`default_nettype none
module gmr_props #(
	parameter int ADDR_W = 12
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic internal_update,
	input wire logic external_update,
	input wire logic [gmr_pkg::WIDTH_BITS-1:0] width_field,
	input wire logic shown_buffer_select,
	input wire logic [gmr_pkg::FB_BITS-1:0] display_addr_top,
	input wire logic [gmr_pkg::FB_BITS-1:0] origin_addr_top
);
	logic wr_go;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// address and data taken at one edge
	assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	// ******************
	// bus timing
	// ******************
	property p_write_ans; wr_go |=> s_axi_bvalid; endproperty
	a_write_ans: assert property (p_write_ans) else $error("no write answer");
	property p_read_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
	a_read_ans: assert property (p_read_ans) else $error("no read answer");
	property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_bhold: assert property (p_bhold) else $error("write answer dropped");
	property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rhold: assert property (p_rhold) else $error("read answer dropped");
	property p_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_busy: assert property (p_busy) else $error("second write accepted");
	property p_unmapped; s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'hffc
		|=> s_axi_rresp == gmr_pkg::RESP_SLVERR && s_axi_rdata == 32'h0; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
	// ******************
	// region fields
	// ******************
	property p_width; wr_go && s_axi_awaddr == 12'h020 && s_axi_wstrb[1:0] == 2'h3
		|=> width_field == $past(s_axi_wdata[9:0]); endproperty
	a_width: assert property (p_width) else $error("width not stored");
	property p_swap; $changed(shown_buffer_select) && !$past(internal_update)
		&& !$past(external_update) |-> display_addr_top == $past(origin_addr_top)
		&& origin_addr_top == $past(display_addr_top); endproperty
	a_swap: assert property (p_swap) else $error("buffers not swapped");
	// displayed base moves only on an update strobe or a select change
	property p_display_moves; $changed(display_addr_top) |-> $past(internal_update)
		|| $past(external_update) || $changed(shown_buffer_select); endproperty
	a_display_moves: assert property (p_display_moves) else $error("display moved alone");
endmodule
bind gmr_regs gmr_props #(.ADDR_W(ADDR_W)) u_props (.*);
`default_nettype wire

// *** tb.sv ***
// self-checking bench for the region register bank
// assumes gmr_pkg, gmr_regs and gmr_props compiled before it
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin mismatches++; \
	$display("mismatch %s expected %h seen %h", n, e, a); end end
module tb;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [11:0] awa = 12'h0;
	logic [11:0] ara = 12'h0;
	logic [31:0] wd = 32'h0;
	logic [3:0] ws = 4'hf;
	logic awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0, iu = 1'h0, eu = 1'h0;
	logic awr, wrd, bv, arr, rv, sel;
	logic [1:0] bresp, rresp, tb_b;
	logic [31:0] rdat;
	logic [33:0] tb_r;
	logic [9:0] wf;
	logic [8:0] hf;
	logic [5:0] dsp, org, src;
	logic [17:0] la;
	logic [6:0] wk;
	logic [15:0] v[8];
	logic [15:0] msk[8] = '{16'h03ff, 16'h01ff, 16'h003f, 16'h003f, 16'h007f, 16'hffe0,
		16'h007e, 16'h007f};
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	integer seed = 32'h936baa34;
	int mismatches = 0, comparisons = 0, stall = 0;
	gmr_regs dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
		.s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
		.s_axi_rready(rr), .internal_update(iu), .external_update(eu), .width_field(wf),
		.height_field(hf), .shown_buffer_select(sel), .display_addr_top(dsp),
		.origin_addr_top(org), .list_addr(la), .source_addr_top(src), .work_addr_top(wk));
	initial forever #10 aclk = ~aclk;
	// bus write; bready held back by stall cycles to test answer holding
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
		bq.push_back(e);
		awa <= a;
		wd <= d;
		awv <= 1'h1;
		wv <= 1'h1;
		@(posedge aclk);
		// each channel released at the edge where it is taken
		while (awv || wv) begin
			if (awv && awr) awv <= 1'h0;
			if (wv && wrd) wv <= 1'h0;
			@(posedge aclk);
		end
		repeat (stall) @(posedge aclk);
		br <= 1'h1;
		do @(posedge aclk); while (!bv);
		br <= 1'h0;
	endtask
	// bus read; expectation is {rresp, rdata}
	task automatic rd(input logic [11:0] a, input logic [33:0] e);
		rq.push_back(e);
		ara <= a;
		arv <= 1'h1;
		do @(posedge aclk); while (!arr);
		arv <= 1'h0;
		repeat (stall) @(posedge aclk);
		rr <= 1'h1;
		do @(posedge aclk); while (!rv);
		rr <= 1'h0;
	endtask
	// one-cycle update strobes, then let outputs settle
	task automatic pulse(input logic i, input logic e);
		iu <= i;
		eu <= e;
		@(posedge aclk);
		iu <= 1'h0;
		eu <= 1'h0;
		repeat (2) @(posedge aclk);
	endtask
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// answers are compared here, oldest expectation first
	always @(posedge aclk) begin
		if (bv && br) begin
			tb_b = bq.pop_front();
			`CHK("bresp", tb_b, bresp)
		end
		if (rv && rr) begin
			tb_r = rq.pop_front();
			`CHK("read", tb_r, {rresp, rdat})
		end
	end
	// watchdog; the whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge aclk);
		mismatches++;
		end_sim;
	end
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		foreach (v[k]) begin
			v[k] = 16'($random(seed)) & msk[k];
			wr(12'h020 + 12'(4 * k), {16'h0, v[k]}, gmr_pkg::RESP_OKAY);
		end
		ws <= 4'h1;
		wr(12'h020, 32'h000003c3, gmr_pkg::RESP_OKAY);
		ws <= 4'hf;
		v[0][7:0] = 8'hc3;
		stall = 2;
		foreach (v[k]) rd(12'h020 + 12'(4 * k), {gmr_pkg::RESP_OKAY, 16'h0, v[k]});
		stall = 0;
		`CHK("width", v[0][9:0], wf)
		`CHK("height", v[1][8:0], hf)
		`CHK("list", {v[4][6:0], v[5][15:5]}, la)
		`CHK("source", v[6][6:1], src)
		`CHK("work", v[7][6:0], wk)
		$display("region registers done");
		pulse(1'h1, 1'h1);
		`CHK("display", v[2][5:0], dsp)
		`CHK("origin", v[3][5:0], org)
		wr(12'h028, 32'h15, gmr_pkg::RESP_OKAY);
		wr(12'h02c, 32'h2a, gmr_pkg::RESP_OKAY);
		`CHK("display pending", v[2][5:0], dsp)
		pulse(1'h0, 1'h1);
		`CHK("origin external", 6'h2a, org)
		`CHK("display held", v[2][5:0], dsp)
		pulse(1'h1, 1'h0);
		`CHK("display internal", 6'h15, dsp)
		rd(12'h084, {gmr_pkg::RESP_OKAY, 18'h0, 6'h2a, 2'h0, 6'h15});
		wr(12'h080, 32'h1, gmr_pkg::RESP_OKAY);
		`CHK("swapped display", 6'h2a, dsp)
		`CHK("swapped origin", 6'h15, org)
		$display("buffer updates done");
		rd(12'hffc, {gmr_pkg::RESP_SLVERR, 32'h0});
		wr(12'hffc, 32'h1234, gmr_pkg::RESP_SLVERR);
		rd(12'h040, {gmr_pkg::RESP_OKAY, 32'h0});
		$display("refusals done");
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		`CHK("select after reset", 1'h0, sel)
		`CHK("display kept", 6'h15, dsp)
		`CHK("width kept", v[0][9:0], wf)
		`CHK("work kept", v[7][6:0], wk)
		rd(12'h038, {gmr_pkg::RESP_OKAY, 16'h0, v[6]});
		// let the answer monitor take the last read before closing
		@(posedge aclk);
		$display("reset retention done");
		end_sim;
	end
endmodule
`default_nettype wire
